// *** src/pds_pkg.sv ***
// shared constants and types for the pulse drive sequencer
package pds_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W  = 32;
  localparam int ADDR_W  = 4;
  localparam int SPEED_W = 16;
  localparam int ACCUM_W = 24;

  // ----------------------------------------------------------------
  // register word indices
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CMD        = 4'h0;
  localparam logic [ADDR_W-1:0] REG_PULSE      = 4'h1;
  localparam logic [ADDR_W-1:0] REG_ACCEL      = 4'h2;
  localparam logic [ADDR_W-1:0] REG_DECEL      = 4'h3;
  localparam logic [ADDR_W-1:0] REG_INIT_SPEED = 4'h4;
  localparam logic [ADDR_W-1:0] REG_DRV_SPEED  = 4'h5;
  localparam logic [ADDR_W-1:0] REG_MODE3      = 4'h6;
  localparam logic [ADDR_W-1:0] REG_MAN_POINT  = 4'h7;
  localparam logic [ADDR_W-1:0] REG_DEC_OFFSET = 4'h8;
  localparam logic [ADDR_W-1:0] REG_STOP_CFG   = 4'h9;
  localparam logic [ADDR_W-1:0] REG_LOGIC_POS  = 4'hA;
  localparam logic [ADDR_W-1:0] REG_STATUS     = 4'hB;
  localparam logic [ADDR_W-1:0] REG_OUT_COUNT  = 4'hC;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_REL       = 8'h50;
  localparam logic [7:0] CMD_CREL      = 8'h51;
  localparam logic [7:0] CMD_CONT_P    = 8'h52;
  localparam logic [7:0] CMD_CONT_M    = 8'h53;
  localparam logic [7:0] CMD_ABS       = 8'h54;
  localparam logic [7:0] CMD_DEC_STOP  = 8'h60;
  localparam logic [7:0] CMD_INST_STOP = 8'h61;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int MODE3_MANUAL_BIT = 0;
  localparam int MODE3_SEPDEC_BIT = 1;
  localparam int STOP_EN_LSB      = 0;
  localparam int STOP_LVL_LSB     = 3;
  localparam logic [DATA_W-1:0]  DEC_OFFSET_RST = 32'h0000_0000;
  localparam logic [SPEED_W-1:0] SPEED_RST      = 16'h0000;
  localparam logic [5:0]         STOP_CFG_RST   = 6'h00;

  typedef enum logic [1:0] {
    PDS_IDLE  = 2'b00,
    PDS_ACCEL = 2'b01,
    PDS_CONST = 2'b10,
    PDS_DECEL = 2'b11
  } pds_state_t;

  typedef enum logic [1:0] {
    PDS_MV_REL  = 2'b00,
    PDS_MV_CREL = 2'b01,
    PDS_MV_ABS  = 2'b10,
    PDS_MV_CONT = 2'b11
  } pds_move_t;

endpackage

// *** src/pds_rate_accum.sv ***
// fractional rate accumulator: one tick per carry out of the sum
`timescale 1ns/10ps
`default_nettype none
module pds_rate_accum #(
  parameter int ACC_W  = 24,
  parameter int RATE_W = 16
) (
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic              clear,
  input  wire logic [RATE_W-1:0] rate,
  output var  logic              tick
);
  logic [ACC_W-1:0] acc;
  logic [ACC_W:0]   sum;

  assign sum = {1'b0, acc} + {{(ACC_W - RATE_W + 1){1'b0}}, rate};

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      acc  <= '0;
      tick <= 1'b0;
    end else if (clear) begin
      acc  <= '0;
      tick <= 1'b0;
    end else begin
      acc  <= sum[ACC_W-1:0];
      tick <= sum[ACC_W];
    end
  end
endmodule
`default_nettype wire

// *** src/pds_sequencer.sv ***
// single-axis pulse drive sequencer with register port and stop inputs
// Notes on behaviour
// - fixed moves end on count, continuous on stop
// - command 50h starts a relative move
// - relative move direction follows count sign
// - auto decel below accel pulses, end when done
// - command 54h absolute move from position difference
// - command 51h counter relative, direction reversed
// - count rewrite in relative moves keeps direction
// - absolute move refuses count rewrite while driving
// - enlarged count during decel accelerates again
// - count below output pulses stops instantly
// - rewrite in decel need not track curves
// - manual decel bit uses loaded decel point
// - positive offset advances deceleration point
// - negative offset delays deceleration point
// - decel offset is zero after reset
// - decelerating stop and instant stop commands
// - external stops decelerate, instant at slow speed
// - each stop input has enable and level
// - commands 52h and 53h run continuous moves
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module pds_sequencer
  import pds_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output var  logic [DATA_W-1:0] regRdData,
  input  wire logic [2:0]        extStopIn,
  output var  logic              pulsePlus,
  output var  logic              pulseMinus,
  output var  logic              driving
);
  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [DATA_W-1:0]  drivePulseCount;
  logic [SPEED_W-1:0] accelRate;
  logic [SPEED_W-1:0] decelRate;
  logic [SPEED_W-1:0] initialSpeed;
  logic [SPEED_W-1:0] driveSpeed;
  logic [1:0]         modeRegisterThree;
  logic [DATA_W-1:0]  manualPoint;
  logic [DATA_W-1:0]  decelOffset;
  logic [5:0]         stopCfg;
  logic [DATA_W-1:0]  logicalPos;
  pds_state_t         state;
  pds_move_t          moveKind;
  logic               dirPlus;
  logic               stopReq;
  logic [DATA_W-1:0]  totalPulses;
  logic [DATA_W-1:0]  outCount;
  logic [DATA_W-1:0]  accelPulses;
  logic [SPEED_W-1:0] speed;
  logic [SPEED_W-1:0] baseSpeed;
  logic [2:0]         stopSync1;
  logic [2:0]         stopSync2;
  logic [2:0]         stopSync3;
  logic [2:0]         stopLevel;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic               wrCmd;
  logic [7:0]         cmd;
  logic               startCmd;
  logic               instStop;
  logic               softStop;
  logic               anyExtStop;
  logic               isFixed;
  logic               fixedDone;
  logic               overrideWr;
  logic               overrideOk;
  logic               sameDir;
  logic               shrinkStop;
  logic               pulseWrOk;
  logic [DATA_W-1:0]  wMag;
  logic [DATA_W-1:0]  relMag;
  logic signed [32:0] absDiff;
  logic [32:0]        absMag;
  logic               startDir;
  logic [DATA_W-1:0]  startMag;
  pds_move_t          startKind;
  logic [SPEED_W-1:0] startSpeed;
  logic [DATA_W-1:0]  remaining;
  logic signed [33:0] remWide;
  logic signed [33:0] autoPoint;
  logic               decelPoint;
  logic               rateTick;
  logic               accelTick;
  logic               emit;
  logic [SPEED_W-1:0] accelUse;
  logic [SPEED_W-1:0] pulseRate;

  assign wrCmd    = regWr && (regAddr == REG_CMD);
  assign cmd      = regWrData[7:0];
  assign startCmd = wrCmd && (state == PDS_IDLE) && (cmd >= CMD_REL) && (cmd <= CMD_ABS);
  assign instStop = wrCmd && (cmd == CMD_INST_STOP);
  assign isFixed  = (moveKind != PDS_MV_CONT);
  assign fixedDone = isFixed && (outCount >= totalPulses);

  // ----------------------------------------------------------------
  // start decode
  // ----------------------------------------------------------------
  assign relMag  = drivePulseCount[31] ? DATA_W'(-drivePulseCount) : drivePulseCount;
  assign absDiff = $signed({drivePulseCount[31], drivePulseCount})
                 - $signed({logicalPos[31], logicalPos});
  assign absMag  = absDiff[32] ? 33'(-absDiff) : 33'(absDiff);
  assign startSpeed = (driveSpeed > initialSpeed) ? initialSpeed : driveSpeed;

  always_comb begin
    startKind = PDS_MV_REL;
    startDir  = !drivePulseCount[31];
    startMag  = relMag;
    case (cmd)
      CMD_CREL: begin
        startKind = PDS_MV_CREL;
        startDir  = drivePulseCount[31];
      end
      CMD_ABS: begin
        startKind = PDS_MV_ABS;
        startDir  = !absDiff[32];
        startMag  = absMag[DATA_W-1:0];
      end
      CMD_CONT_P: begin
        startKind = PDS_MV_CONT;
        startDir  = 1'b1;
      end
      CMD_CONT_M: begin
        startKind = PDS_MV_CONT;
        startDir  = 1'b0;
      end
      default: begin
        startKind = PDS_MV_REL;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // pulse count rewrite while driving
  // ----------------------------------------------------------------
  assign overrideWr = regWr && (regAddr == REG_PULSE) && (state != PDS_IDLE);
  assign wMag    = regWrData[31] ? DATA_W'(-regWrData) : regWrData;
  assign sameDir = (moveKind == PDS_MV_REL) ? (dirPlus == !regWrData[31])
                                            : (dirPlus == regWrData[31]);
  // absolute moves never take a rewrite; reversals are dropped whole
  assign overrideOk = overrideWr && sameDir
                   && ((moveKind == PDS_MV_REL) || (moveKind == PDS_MV_CREL));
  assign shrinkStop = overrideOk && (wMag < outCount);
  assign pulseWrOk  = regWr && (regAddr == REG_PULSE)
                   && ((state == PDS_IDLE) || (moveKind == PDS_MV_CONT) || overrideOk);

  // ----------------------------------------------------------------
  // deceleration point
  // ----------------------------------------------------------------
  assign remaining = totalPulses - outCount;
  assign remWide   = $signed({2'b00, remaining});
  assign autoPoint = $signed({2'b00, accelPulses})
                   + $signed({{2{decelOffset[31]}}, decelOffset});
  always_comb begin
    decelPoint = 1'b0;
    if (isFixed && !stopReq) begin
      if (modeRegisterThree[MODE3_MANUAL_BIT]) begin
        decelPoint = (remaining <= manualPoint);
      end else begin
        decelPoint = (remWide <= autoPoint);
      end
    end
  end

  // ----------------------------------------------------------------
  // external stop inputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stopSync1 <= 3'h0;
      stopSync2 <= 3'h0;
      stopSync3 <= 3'h0;
      stopLevel <= 3'h0;
    end else begin
      stopSync1 <= extStopIn;
      stopSync2 <= stopSync1;
      stopSync3 <= stopSync2;
      // a bit only moves once the last two stages agree
      stopLevel <= (stopLevel & (stopSync2 ^ stopSync3))
                 | (stopSync2 & ~(stopSync2 ^ stopSync3));
    end
  end

  assign anyExtStop = |(stopCfg[STOP_EN_LSB +: 3]
                      & ~(stopLevel ^ stopCfg[STOP_LVL_LSB +: 3]));
  assign softStop = (wrCmd && (cmd == CMD_DEC_STOP)) || (anyExtStop && !stopReq);

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      drivePulseCount   <= 32'h0000_0000;
      accelRate         <= SPEED_RST;
      decelRate         <= SPEED_RST;
      initialSpeed      <= SPEED_RST;
      driveSpeed        <= SPEED_RST;
      modeRegisterThree <= 2'h0;
      manualPoint       <= 32'h0000_0000;
      decelOffset       <= DEC_OFFSET_RST;
      stopCfg           <= STOP_CFG_RST;
    end else if (regWr) begin
      case (regAddr)
        REG_PULSE:      if (pulseWrOk) drivePulseCount <= regWrData;
        REG_ACCEL:      accelRate <= regWrData[SPEED_W-1:0];
        REG_DECEL:      decelRate <= regWrData[SPEED_W-1:0];
        REG_INIT_SPEED: initialSpeed <= regWrData[SPEED_W-1:0];
        REG_DRV_SPEED:  driveSpeed <= regWrData[SPEED_W-1:0];
        REG_MODE3:      modeRegisterThree <= regWrData[1:0];
        REG_MAN_POINT:  manualPoint <= regWrData;
        REG_DEC_OFFSET: decelOffset <= regWrData;
        REG_STOP_CFG:   stopCfg <= regWrData[5:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // move sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state       <= PDS_IDLE;
      moveKind    <= PDS_MV_REL;
      dirPlus     <= 1'b1;
      stopReq     <= 1'b0;
      totalPulses <= 32'h0000_0000;
      baseSpeed   <= SPEED_RST;
    end else if (state == PDS_IDLE) begin
      stopReq <= 1'b0;
      if (startCmd) begin
        moveKind    <= startKind;
        dirPlus     <= startDir;
        totalPulses <= startMag;
        baseSpeed   <= startSpeed;
        state       <= (driveSpeed > initialSpeed) ? PDS_ACCEL : PDS_CONST;
      end
    end else begin
      if (overrideOk) begin
        totalPulses <= wMag;
      end
      if (instStop || shrinkStop) begin
        state <= PDS_IDLE;
      end else if (fixedDone) begin
        state <= PDS_IDLE;
      end else if (softStop) begin
        if (speed <= initialSpeed) begin
          state <= PDS_IDLE;
        end else begin
          stopReq <= 1'b1;
          state   <= PDS_DECEL;
        end
      end else if (stopReq && (speed <= baseSpeed)) begin
        state <= PDS_IDLE;
      end else begin
        case (state)
          PDS_ACCEL: begin
            if (decelPoint) state <= PDS_DECEL;
            else if (speed >= driveSpeed) state <= PDS_CONST;
          end
          PDS_CONST: begin
            if (decelPoint) state <= PDS_DECEL;
          end
          PDS_DECEL: begin
            // linear ramp only; curved profiles are not retraced here
            if (!stopReq && isFixed && !decelPoint) begin
              state <= (speed < driveSpeed) ? PDS_ACCEL : PDS_CONST;
            end
          end
          default: begin
            state <= PDS_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // speed ramp
  // ----------------------------------------------------------------
  assign accelUse = (state == PDS_ACCEL) ? accelRate
                  : (state == PDS_DECEL)
                    ? (modeRegisterThree[MODE3_SEPDEC_BIT] ? decelRate : accelRate)
                  : SPEED_RST;
  assign pulseRate = (state == PDS_IDLE) ? SPEED_RST : speed;

  pds_rate_accum #(.ACC_W(ACCUM_W), .RATE_W(SPEED_W)) uAccelAccum (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .clear   ((state == PDS_IDLE) || (state == PDS_CONST)),
    .rate    (accelUse),
    .tick    (accelTick)
  );

  pds_rate_accum #(.ACC_W(ACCUM_W), .RATE_W(SPEED_W)) uPulseAccum (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .clear   (state == PDS_IDLE),
    .rate    (pulseRate),
    .tick    (rateTick)
  );

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      speed <= SPEED_RST;
    end else if (state == PDS_IDLE) begin
      if (startCmd) speed <= startSpeed;
    end else if (accelTick) begin
      if ((state == PDS_ACCEL) && (speed < driveSpeed)) speed <= speed + 16'h0001;
      else if ((state == PDS_DECEL) && (speed > baseSpeed)) speed <= speed - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // pulse output and counters
  // ----------------------------------------------------------------
  assign emit = (state != PDS_IDLE) && rateTick && !instStop && !shrinkStop
             && (!isFixed || (outCount < totalPulses));

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      outCount    <= 32'h0000_0000;
      accelPulses <= 32'h0000_0000;
    end else if (startCmd) begin
      outCount    <= 32'h0000_0000;
      accelPulses <= 32'h0000_0000;
    end else if (emit) begin
      outCount <= outCount + 32'h0000_0001;
      if (state == PDS_ACCEL) accelPulses <= accelPulses + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      logicalPos <= 32'h0000_0000;
    end else if (emit) begin
      logicalPos <= dirPlus ? logicalPos + 32'h0000_0001 : logicalPos - 32'h0000_0001;
    end else if (regWr && (regAddr == REG_LOGIC_POS) && (state == PDS_IDLE)) begin
      logicalPos <= regWrData;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pulsePlus  <= 1'b0;
      pulseMinus <= 1'b0;
      driving    <= 1'b0;
    end else begin
      pulsePlus  <= emit && dirPlus;
      pulseMinus <= emit && !dirPlus;
      driving    <= (state != PDS_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 32'h0000_0000;
    end else if (regRd) begin
      case (regAddr)
        REG_PULSE:      regRdData <= drivePulseCount;
        REG_ACCEL:      regRdData <= {16'h0000, accelRate};
        REG_DECEL:      regRdData <= {16'h0000, decelRate};
        REG_INIT_SPEED: regRdData <= {16'h0000, initialSpeed};
        REG_DRV_SPEED:  regRdData <= {16'h0000, driveSpeed};
        REG_MODE3:      regRdData <= {30'h0000_0000, modeRegisterThree};
        REG_MAN_POINT:  regRdData <= manualPoint;
        REG_DEC_OFFSET: regRdData <= decelOffset;
        REG_STOP_CFG:   regRdData <= {26'h000_0000, stopCfg};
        REG_LOGIC_POS:  regRdData <= logicalPos;
        REG_STATUS:     regRdData <= {7'h00, speed, stopLevel, stopReq,
                                      dirPlus, moveKind, state};
        REG_OUT_COUNT:  regRdData <= outCount;
        default:        regRdData <= 32'h0000_0000;
      endcase
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_fixed_limit;
    @(posedge clk_sys) disable iff (!nrst)
    (state != PDS_IDLE) && isFixed |-> outCount <= totalPulses;
  endproperty
  a_fixed_limit: assert property (p_fixed_limit) else $error("fixed move overran");

  property p_inst_stop;
    @(posedge clk_sys) disable iff (!nrst)
    instStop && (state != PDS_IDLE) |=> (state == PDS_IDLE) ##1 !pulsePlus && !pulseMinus;
  endproperty
  a_inst_stop: assert property (p_inst_stop) else $error("instant stop not taken");

  property p_abs_locked;
    @(posedge clk_sys) disable iff (!nrst)
    overrideWr && (moveKind == PDS_MV_ABS) |=> $stable(drivePulseCount) && $stable(totalPulses);
  endproperty
  a_abs_locked: assert property (p_abs_locked) else $error("absolute count changed");

  property p_reverse_ignored;
    @(posedge clk_sys) disable iff (!nrst)
    overrideWr && !sameDir && (moveKind != PDS_MV_CONT) |=> $stable(totalPulses);
  endproperty
  a_reverse_ignored: assert property (p_reverse_ignored) else $error("reversal taken");

  property p_shrink_stop;
    @(posedge clk_sys) disable iff (!nrst)
    shrinkStop |=> (state == PDS_IDLE) && (totalPulses == $past(wMag));
  endproperty
  a_shrink_stop: assert property (p_shrink_stop) else $error("shrink did not stop");

  property p_rel_dir;
    @(posedge clk_sys) disable iff (!nrst)
    startCmd && (cmd == CMD_REL) |=> dirPlus == !$past(drivePulseCount[31]);
  endproperty
  a_rel_dir: assert property (p_rel_dir) else $error("relative direction wrong");

  property p_crel_dir;
    @(posedge clk_sys) disable iff (!nrst)
    startCmd && (cmd == CMD_CREL) |=> dirPlus == $past(drivePulseCount[31]);
  endproperty
  a_crel_dir: assert property (p_crel_dir) else $error("counter direction wrong");

  property p_ext_slow_stop;
    @(posedge clk_sys) disable iff (!nrst)
    anyExtStop && (state != PDS_IDLE) && (speed <= initialSpeed) |=> state == PDS_IDLE;
  endproperty
  a_ext_slow_stop: assert property (p_ext_slow_stop) else $error("slow stop late");

  property p_cont_start;
    @(posedge clk_sys) disable iff (!nrst)
    startCmd && (cmd == CMD_CONT_M) |=> (moveKind == PDS_MV_CONT) && !dirPlus ##1 driving;
  endproperty
  a_cont_start: assert property (p_cont_start) else $error("continuous start wrong");

endmodule
`default_nettype wire

// *** testbench/pds_host_model.sv ***
// host processor model driving the sequencer register port
`timescale 1ns/10ps
`default_nettype none
module pds_host_model
  import pds_pkg::*;
(
  input  wire logic              clk_sys,
  output var  logic [ADDR_W-1:0] regAddr,
  output var  logic [DATA_W-1:0] regWrData,
  output var  logic              regWr,
  output var  logic              regRd,
  input  wire logic [DATA_W-1:0] regRdData
);
  initial begin
    regAddr = '0;
    regWrData = '0;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  // strobes last one cycle; a gap cycle keeps each strobe to one driver per step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    d = regRdData;
  endtask
endmodule
`default_nettype wire

// *** testbench/test_pds_sequencer.sv ***
// self-checking bench for the pulse drive sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD %0t value mismatch", $time); end end
module test_pds_sequencer
  import pds_pkg::*;
;
  logic              clk_sys = 1'b0;
  logic              nrst = 1'b0;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData, rdv;
  logic              regWr, regRd, pulsePlus, pulseMinus, driving, lvl;
  logic [2:0]        extStopIn = 3'h0;
  logic [31:0]       nPlus = 32'h0, nMinus = 32'h0, bP, bM;
  int                miscompares = 0, nChecks = 0, cyc = 0, cnt;
  always #50 clk_sys = ~clk_sys;
  pds_host_model u_pds_host_model (.clk_sys(clk_sys), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
  pds_sequencer u_pds_sequencer (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .extStopIn(extStopIn), .pulsePlus(pulsePlus), .pulseMinus(pulseMinus),
    .driving(driving));
  always @(posedge clk_sys) begin
    nPlus <= nPlus + pulsePlus;
    nMinus <= nMinus + pulseMinus;
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input int d);
    u_pds_host_model.wr(a, 32'(d));
  endtask
  function automatic logic dirPlus(input logic [7:0] c, input int n);
    return (c == CMD_CREL) ? (n < 0) : (n >= 0);
  endfunction
  task automatic waitDrv(input logic v, input int lim);
    for (int i = 0; i < lim && driving !== v; i++) @(posedge clk_sys);
    `CHK(driving, v)
  endtask
  task automatic go(input logic [7:0] c, input int n);
    bP = nPlus;
    bM = nMinus;
    wr(REG_PULSE, n);
    wr(REG_CMD, int'(c));
    waitDrv(1'b1, 8);
  endtask
  task automatic done(input logic [7:0] c, input int n, input int lim);
    int m;
    m = (n < 0) ? -n : n;
    waitDrv(1'b0, lim);
    `CHK(nPlus - bP, 32'(dirPlus(c, n) ? m : 0))
    `CHK(nMinus - bM, 32'(dirPlus(c, n) ? 0 : m))
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(6289));
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    u_pds_host_model.rd(REG_DEC_OFFSET, rdv);
    `CHK(rdv, 32'h0)
    u_pds_host_model.rd(4'hF, rdv);
    `CHK(rdv, 32'h0)
    wr(REG_INIT_SPEED, 16'hFFFF);
    wr(REG_DRV_SPEED, 16'hFFFF);
    for (int k = 0; k < 6; k++) begin
      cnt = int'($urandom_range(20, 1));
      if ($urandom % 2) cnt = -cnt;
      go((k % 2) ? CMD_CREL : CMD_REL, cnt);
      done((k % 2) ? CMD_CREL : CMD_REL, cnt, 6000);
    end
    wr(REG_LOGIC_POS, 5);
    go(CMD_ABS, 2);
    done(CMD_REL, -3, 1000);
    wr(REG_INIT_SPEED, 16'h8000);
    wr(REG_DRV_SPEED, 16'h8000);
    go(CMD_ABS, 5);
    repeat (700) @(posedge clk_sys);
    wr(REG_PULSE, 1);
    done(CMD_REL, 3, 3000);
    go(CMD_REL, 4);
    repeat (700) @(posedge clk_sys);
    wr(REG_PULSE, -2);
    done(CMD_REL, 4, 3000);
    go(CMD_REL, 4);
    repeat (1200) @(posedge clk_sys);
    wr(REG_PULSE, 1);
    waitDrv(1'b0, 8);
    `CHK(nPlus - bP, 32'd2)
    u_pds_host_model.rd(REG_OUT_COUNT, rdv);
    `CHK(rdv, 32'd2)
    // decel rate never loaded: accel rate serves both ramps
    wr(REG_INIT_SPEED, 16'hF000);
    wr(REG_DRV_SPEED, 16'hFFFF);
    wr(REG_ACCEL, 16'hFFFF);
    wr(REG_MAN_POINT, 5);
    for (int k = 0; k < 4; k++) begin
      wr(REG_MODE3, int'(k == 1));
      wr(REG_DEC_OFFSET, (k == 2) ? 3 : (k == 3) ? -3 : 0);
      // about 273 cycles a pulse near the start speed, so keep moves short
      go(CMD_REL, 12);
      done(CMD_REL, 12, 5000);
    end
    wr(REG_INIT_SPEED, 16'hFFFF);
    for (int k = 0; k < 4; k++) begin
      go((k < 2) ? CMD_CONT_P : CMD_CONT_M, (k < 2) ? 1 : -1);
      // full speed carries every 256 or 257 cycles: two pulses before the stop
      repeat (600) @(posedge clk_sys);
      wr(REG_CMD, int'((k % 2) ? CMD_INST_STOP : CMD_DEC_STOP));
      waitDrv(1'b0, 8);
      `CHK((k < 2) ? nMinus - bM : nPlus - bP, 32'h0)
      `CHK((k < 2) ? nPlus - bP : nMinus - bM, 32'h2)
    end
    for (int k = 0; k < 3; k++) begin
      lvl = 1'($urandom);
      wr(REG_STOP_CFG, 0);
      extStopIn <= lvl ? 3'h0 : 3'h7;
      go(CMD_CONT_P, 1);
      extStopIn[k] <= lvl;
      repeat (20) @(posedge clk_sys);
      `CHK(driving, 1'b1)
      wr(REG_STOP_CFG, (1 << k) | (int'(lvl) << (3 + k)));
      waitDrv(1'b0, 8);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
